// >>> hw/isi_pkg.sv
// Constants, types and register map of the two-wire slave interface
package isi_pkg;

	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STAT = 8'h04;
	localparam logic [7:0] OFF_DATA = 8'h08;
	localparam logic [7:0] OFF_ADDR = 8'h0C;
	localparam logic [7:0] OFF_TOUT = 8'h10;

	localparam int B_DEB_HI = 3;
	localparam int B_DEB_LO = 2;
	localparam int B_EN     = 1;
	localparam int B_TXS    = 4;
	localparam int B_ACKS   = 3;
	localparam int B_MWU    = 1;
	localparam int B_TOF    = 6;
	localparam int B_OWN_HI = 7;
	localparam int B_OWN_LO = 1;

	localparam logic [7:0] STAT_RST  = 8'h81;
	localparam logic [1:0] DEB_NONE  = 2'h0;
	localparam logic [1:0] DEB_TWO   = 2'h1;
	localparam logic [2:0] DEB2_CYC  = 3'h2;
	localparam logic [2:0] DEB4_CYC  = 3'h4;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] LAST_BIT  = 4'h7;

	typedef struct packed {
		logic sda;
		logic scl;
	} isi_bus_t;

	// Field order matches the bit order of the status/control register
	typedef struct packed {
		logic tcf;
		logic amf;
		logic bbf;
		logic txs;
		logic acks;
		logic rwf;
		logic mwu;
		logic ackr;
	} isi_stat_t;

	typedef enum logic [2:0] {
		S_IDLE,
		S_ADDR,
		S_AACK,
		S_HOLD,
		S_RX,
		S_RACK,
		S_TX,
		S_TACK
	} isi_state_t;

	typedef struct packed {
		isi_bus_t   s1;
		isi_bus_t   s2;
		logic [2:0] cnt;
		isi_bus_t   q;
	} isi_filt_t;

	typedef struct packed {
		isi_state_t st;
		logic [3:0] cnt;
		logic [7:0] shreg;
		logic [7:0] data;
		logic [6:0] own;
		logic [1:0] deb;
		logic       en;
		isi_stat_t  stat;
		logic       tof;
		logic       sda_oe;
		logic       scl_oe;
		logic       drv_lvl;
		isi_bus_t   prev;
		logic       irq;
		logic       wake;
		logic [7:0] rdata;
		logic       pready;
		logic       pslverr;
	} isi_core_t;

endpackage

// >>> hw/isi_filt.sv
// Pin synchroniser and selectable debounce for SDA and SCL
`timescale 1ns/1ps
`default_nettype none
module isi_filt (
	input  wire logic             CLK,
	input  wire logic             RESET,
	input  wire isi_pkg::isi_bus_t RAW,
	input  wire logic [1:0]       MODE,
	output var  isi_pkg::isi_bus_t CLEAN
);
	isi_pkg::isi_filt_t r;
	isi_pkg::isi_filt_t n;
	logic [2:0]         need;

	always_comb begin
		n = r;
		n.s1 = RAW;
		n.s2 = r.s1;
		need = (MODE == isi_pkg::DEB_TWO) ? isi_pkg::DEB2_CYC : isi_pkg::DEB4_CYC;
		if (MODE == isi_pkg::DEB_NONE) begin
			n.q = r.s2;
			n.cnt = 3'h0;
		end else if (r.s2 == r.q) begin
			n.cnt = 3'h0;
		end else if (r.cnt + 3'h1 >= need) begin
			n.q = r.s2;
			n.cnt = 3'h0;
		end else begin
			n.cnt = r.cnt + 3'h1;
		end
	end

	// Idle bus is high, so the chain resets to high to avoid a false edge
	always_ff @(posedge CLK) begin
		if (RESET) begin
			r <= '{s1: 2'h3, s2: 2'h3, cnt: 3'h0, q: 2'h3};
		end else begin
			r <= n;
		end
	end

	assign CLEAN = r.q;
endmodule
`default_nettype wire

// >>> hw/isi_top.sv
// Two-wire bus slave with APB register access
`timescale 1ns/1ps
`default_nettype none
module isi_top (
	input  wire logic        CLK,
	input  wire logic        RESET,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic [31:0]      PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        SDA_IN,
	output logic             SDA_OUT,
	output logic             SDA_OE,
	input  wire logic        SCL_IN,
	output logic             SCL_OUT,
	output logic             SCL_OE,
	input  wire logic        HS_CLOCK_SEL,
	input  wire logic        TIMEOUT_EVENT,
	output logic             IRQ,
	output logic             WAKE
);
	isi_pkg::isi_core_t r;
	isi_pkg::isi_core_t n;
	isi_pkg::isi_bus_t  raw;
	isi_pkg::isi_bus_t  cln;
	logic [1:0]         filt_mode;
	logic               acc;
	logic               cmt;
	logic               wr_cmt;
	logic               rd_cmt;
	logic               scl_rise;
	logic               scl_fall;
	logic               start_ev;
	logic               stop_ev;
	logic               rel;

	function automatic logic is_reg(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		return is_reg(a, isi_pkg::OFF_CTRL) || is_reg(a, isi_pkg::OFF_STAT) ||
			is_reg(a, isi_pkg::OFF_DATA) || is_reg(a, isi_pkg::OFF_ADDR) ||
			is_reg(a, isi_pkg::OFF_TOUT);
	endfunction

	assign raw = '{sda: SDA_IN, scl: SCL_IN};
	// Slow-clock wake-up cannot afford the debounce delay
	assign filt_mode = (HS_CLOCK_SEL || !r.stat.mwu) ? r.deb : isi_pkg::DEB_NONE;

	isi_filt u_filt (
		.CLK   (CLK),
		.RESET (RESET),
		.RAW   (raw),
		.MODE  (filt_mode),
		.CLEAN (cln)
	);

	// One wait state: the answer is prepared in the first access cycle
	assign acc = PSEL && PENABLE && !r.pready;
	assign cmt = PSEL && PENABLE && r.pready;
	assign wr_cmt = cmt && PWRITE && mapped(PADDR);
	assign rd_cmt = cmt && !PWRITE && mapped(PADDR);

	assign scl_rise = cln.scl && !r.prev.scl;
	assign scl_fall = !cln.scl && r.prev.scl;
	assign start_ev = r.prev.sda && !cln.sda && cln.scl && r.prev.scl;
	assign stop_ev = !r.prev.sda && cln.sda && cln.scl && r.prev.scl;
	assign rel = (r.stat.txs && wr_cmt && is_reg(PADDR, isi_pkg::OFF_DATA)) ||
		(!r.stat.txs && rd_cmt && is_reg(PADDR, isi_pkg::OFF_DATA));

	always_comb begin
		n = r;
		n.irq = 1'b0;
		n.wake = 1'b0;
		n.prev = cln;
		n.pready = acc;
		if (acc) begin
			n.pslverr = !mapped(PADDR);
			case (PADDR)
				isi_pkg::OFF_CTRL: begin
					n.rdata = 8'h00;
					n.rdata[isi_pkg::B_DEB_HI:isi_pkg::B_DEB_LO] = r.deb;
					n.rdata[isi_pkg::B_EN] = r.en;
				end
				isi_pkg::OFF_STAT: n.rdata = r.stat;
				isi_pkg::OFF_DATA: n.rdata = r.data;
				isi_pkg::OFF_ADDR: n.rdata = {r.own, 1'b0};
				isi_pkg::OFF_TOUT: begin
					n.rdata = 8'h00;
					n.rdata[isi_pkg::B_TOF] = r.tof;
				end
				default: n.rdata = 8'h00;
			endcase
		end else if (!PSEL) begin
			n.pslverr = 1'b0;
		end

		// Software side effects first, so hardware events below win
		if (rd_cmt && is_reg(PADDR, isi_pkg::OFF_DATA)) begin
			n.stat.tcf = 1'b0;
		end
		if (wr_cmt) begin
			case (PADDR)
				isi_pkg::OFF_CTRL: begin
					n.deb = PWDATA[isi_pkg::B_DEB_HI:isi_pkg::B_DEB_LO];
					n.en = PWDATA[isi_pkg::B_EN];
					if (!r.en && PWDATA[isi_pkg::B_EN]) begin
						n.stat.tcf = 1'b1;
						n.stat.amf = 1'b0;
						n.stat.bbf = 1'b0;
						n.stat.rwf = 1'b0;
						n.stat.ackr = 1'b1;
					end
				end
				isi_pkg::OFF_STAT: begin
					n.stat.txs = PWDATA[isi_pkg::B_TXS];
					n.stat.acks = PWDATA[isi_pkg::B_ACKS];
					n.stat.mwu = PWDATA[isi_pkg::B_MWU];
				end
				isi_pkg::OFF_DATA: n.data = PWDATA[7:0];
				isi_pkg::OFF_ADDR: n.own = PWDATA[isi_pkg::B_OWN_HI:isi_pkg::B_OWN_LO];
				isi_pkg::OFF_TOUT: begin
					if (!PWDATA[isi_pkg::B_TOF]) begin
						n.tof = 1'b0;
					end
				end
				default: n.en = r.en;
			endcase
		end

		if (!r.en) begin
			n.st = isi_pkg::S_IDLE;
			n.sda_oe = 1'b0;
			n.scl_oe = 1'b0;
			n.cnt = 4'h0;
		end else if (start_ev) begin
			// A START is never driven here; only observed from the master
			n.stat.bbf = 1'b1;
			n.stat.tcf = 1'b0;
			n.st = isi_pkg::S_ADDR;
			n.cnt = 4'h0;
			n.sda_oe = 1'b0;
			n.scl_oe = 1'b0;
		end else if (stop_ev) begin
			n.stat.bbf = 1'b0;
			n.stat.tcf = 1'b1;
			n.st = isi_pkg::S_IDLE;
			n.sda_oe = 1'b0;
			n.scl_oe = 1'b0;
		end else begin
			case (r.st)
				isi_pkg::S_ADDR: begin
					if (scl_rise) begin
						n.shreg = {r.shreg[6:0], cln.sda};
						n.cnt = r.cnt + 4'h1;
					end
					if (scl_fall && r.cnt == isi_pkg::BYTE_BITS) begin
						n.stat.rwf = r.shreg[0];
						n.cnt = 4'h0;
						if (r.shreg[7:1] == r.own) begin
							n.stat.amf = 1'b1;
							n.irq = 1'b1;
							n.wake = r.stat.mwu;
							n.sda_oe = 1'b1;
							n.st = isi_pkg::S_AACK;
						end else begin
							n.stat.amf = 1'b0;
							n.st = isi_pkg::S_IDLE;
						end
					end
				end
				isi_pkg::S_AACK: begin
					if (scl_fall) begin
						n.sda_oe = 1'b0;
						n.scl_oe = 1'b1;
						n.st = isi_pkg::S_HOLD;
					end
				end
				isi_pkg::S_HOLD: begin
					if (rel) begin
						n.scl_oe = 1'b0;
						n.stat.tcf = 1'b0;
						n.cnt = 4'h0;
						if (r.stat.txs) begin
							n.st = isi_pkg::S_TX;
							n.shreg = PWDATA[7:0];
							n.sda_oe = !PWDATA[7];
						end else begin
							n.st = isi_pkg::S_RX;
						end
					end
				end
				isi_pkg::S_RX: begin
					if (scl_rise) begin
						n.shreg = {r.shreg[6:0], cln.sda};
						n.cnt = r.cnt + 4'h1;
					end
					if (scl_fall && r.cnt == isi_pkg::BYTE_BITS) begin
						n.data = r.shreg;
						n.stat.tcf = 1'b1;
						n.irq = 1'b1;
						n.sda_oe = !r.stat.acks;
						n.cnt = 4'h0;
						n.st = isi_pkg::S_RACK;
					end
				end
				isi_pkg::S_RACK: begin
					if (scl_fall) begin
						n.sda_oe = 1'b0;
						if (r.stat.acks) begin
							n.st = isi_pkg::S_IDLE;
						end else begin
							n.scl_oe = 1'b1;
							n.st = isi_pkg::S_HOLD;
						end
					end
				end
				isi_pkg::S_TX: begin
					if (scl_fall) begin
						n.cnt = r.cnt + 4'h1;
						if (r.cnt == isi_pkg::LAST_BIT) begin
							n.sda_oe = 1'b0;
							n.stat.tcf = 1'b1;
							n.irq = 1'b1;
							n.st = isi_pkg::S_TACK;
						end else begin
							n.shreg = {r.shreg[6:0], 1'b0};
							n.sda_oe = !r.shreg[6];
						end
					end
				end
				isi_pkg::S_TACK: begin
					if (scl_rise) begin
						n.stat.ackr = cln.sda;
					end
					if (scl_fall) begin
						n.cnt = 4'h0;
						if (!r.stat.ackr) begin
							n.scl_oe = 1'b1;
							n.st = isi_pkg::S_HOLD;
						end else begin
							n.st = isi_pkg::S_IDLE;
						end
					end
				end
				default: n.st = isi_pkg::S_IDLE;
			endcase
		end

		// Time-out returns status to its reset value and frees the bus
		if (r.en && TIMEOUT_EVENT) begin
			n.stat = isi_pkg::STAT_RST;
			n.tof = 1'b1;
			n.irq = 1'b1;
			n.st = isi_pkg::S_IDLE;
			n.sda_oe = 1'b0;
			n.scl_oe = 1'b0;
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			r <= '{st: isi_pkg::S_IDLE, cnt: 4'h0, shreg: 8'h00, data: 8'h00,
				own: 7'h00, deb: 2'h0, en: 1'b0, stat: isi_pkg::STAT_RST,
				tof: 1'b0, sda_oe: 1'b0, scl_oe: 1'b0, drv_lvl: 1'b0,
				prev: 2'h3, irq: 1'b0, wake: 1'b0, rdata: 8'h00,
				pready: 1'b0, pslverr: 1'b0};
		end else begin
			r <= n;
		end
	end

	assign PRDATA = {24'h000000, r.rdata};
	assign PREADY = r.pready;
	assign PSLVERR = r.pslverr;
	assign SDA_OUT = r.drv_lvl;
	assign SDA_OE = r.sda_oe;
	assign SCL_OUT = r.drv_lvl;
	assign SCL_OE = r.scl_oe;
	assign IRQ = r.irq;
	assign WAKE = r.wake;

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RESET);

	property p_start_busy;
		r.en && start_ev && !TIMEOUT_EVENT |=> r.stat.bbf && !r.stat.tcf && r.st == isi_pkg::S_ADDR;
	endproperty
	a_start_busy: assert property (p_start_busy) else $error("START did not set busy");

	property p_stop_free;
		r.en && stop_ev && !start_ev && !TIMEOUT_EVENT |=> !r.stat.bbf && r.stat.tcf;
	endproperty
	a_stop_free: assert property (p_stop_free) else $error("STOP did not free bus");

	property p_en_rise;
		!r.en && wr_cmt && is_reg(PADDR, isi_pkg::OFF_CTRL) && PWDATA[isi_pkg::B_EN]
			&& !TIMEOUT_EVENT
		|=> r.stat.tcf && !r.stat.amf && !r.stat.bbf && !r.stat.rwf && r.stat.ackr
			&& r.stat.txs == $past(r.stat.txs) && r.stat.acks == $past(r.stat.acks);
	endproperty
	a_en_rise: assert property (p_en_rise) else $error("enable rise flags wrong");

	property p_disabled;
		!r.en ##1 !r.en |-> !SDA_OE && !SCL_OE && r.st == isi_pkg::S_IDLE;
	endproperty
	a_disabled: assert property (p_disabled) else $error("disabled block drives pins");

	property p_match;
		r.en && !start_ev && !stop_ev && !TIMEOUT_EVENT && r.st == isi_pkg::S_ADDR && scl_fall
			&& r.cnt == isi_pkg::BYTE_BITS && r.shreg[7:1] == r.own
		|=> IRQ && r.stat.amf && SDA_OE && r.stat.rwf == $past(r.shreg[0]);
	endproperty
	a_match: assert property (p_match) else $error("address match not flagged");

	property p_hold;
		r.en && !start_ev && !stop_ev && !TIMEOUT_EVENT && r.st == isi_pkg::S_AACK && scl_fall
		|=> SCL_OE ##1 (SCL_OE || rel || !r.en || r.st != isi_pkg::S_HOLD);
	endproperty
	a_hold: assert property (p_hold) else $error("SCL not held after match");

	property p_ack_send;
		r.en && !start_ev && !stop_ev && !TIMEOUT_EVENT && r.st == isi_pkg::S_RX && scl_fall
			&& r.cnt == isi_pkg::BYTE_BITS
		|=> SDA_OE == !$past(r.stat.acks) && r.stat.tcf && IRQ;
	endproperty
	a_ack_send: assert property (p_ack_send) else $error("ack bit not driven");

	property p_ack_received_flag;
		r.en && !start_ev && !stop_ev && !TIMEOUT_EVENT && r.st == isi_pkg::S_TACK && scl_rise
		|=> r.stat.ackr == $past(cln.sda);
	endproperty
	a_ack_received_flag: assert property (p_ack_received_flag) else $error("received ack not sampled");

	property p_sda_low_scl;
		r.en && $past(r.en) && $changed(SDA_OE) && !$past(TIMEOUT_EVENT) |-> !$past(cln.scl);
	endproperty
	a_sda_low_scl: assert property (p_sda_low_scl) else $error("SDA moved with SCL high");

	c_match: cover property (r.st == isi_pkg::S_ADDR ##1 r.st == isi_pkg::S_AACK);
	c_rx_byte: cover property (r.st == isi_pkg::S_RX ##1 r.st == isi_pkg::S_RACK);
	c_tx_byte: cover property (r.st == isi_pkg::S_TX ##1 r.st == isi_pkg::S_TACK);
	c_stop: cover property (r.stat.bbf ##1 !r.stat.bbf);
endmodule
`default_nettype wire

// >>> verification/isi_bus_master.sv
// Behavioural two-wire bus master that honours clock stretching
`timescale 1ns/1ps
`default_nettype none
module isi_bus_master (
	input  wire logic sda,
	input  wire logic scl,
	output var logic  sda_low,
	output var logic  scl_low
);
	initial begin
		sda_low = 1'b0;
		scl_low = 1'b0;
	end
	// Callers start on a rising edge; the offset keeps every pin change off both clock edges
	task automatic start;
		#10;
		#160 sda_low = 1'b1;
		#160 scl_low = 1'b1;
	endtask
	// Long low phase leaves the slave time to set its bit after its input filter
	task automatic bit_io(input logic b, output logic s);
		#100 sda_low = !b;
		#100 scl_low = 1'b0;
		while (!scl) #40;
		#80 s = sda;
		#40 scl_low = 1'b1;
	endtask
	task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
			output logic ack_out);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], q[i]);
		end
		bit_io(ack_in, ack_out);
	endtask
	task automatic stop;
		#100 sda_low = 1'b1;
		#100 scl_low = 1'b0;
		while (!scl) #40;
		#160 sda_low = 1'b0;
		#160;
	endtask
	// SDA dip with SCL high: a START and a STOP unless the input filter swallows it
	task automatic glitch(input int ns);
		#10 sda_low = 1'b1;
		#(ns) sda_low = 1'b0;
		#400;
	endtask
endmodule
`default_nettype wire

// >>> verification/i2c_slave_interface_bench.sv
// Self-checking bench for the two-wire slave, driven by a behavioural bus master
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
$display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module i2c_slave_interface_bench;
	typedef struct packed {
		logic       w;
		logic [7:0] a;
		logic [7:0] d;
		logic [7:0] e;
		logic       err;
	} isi_row_t;
	isi_row_t rows [0:13] = '{
		'{1'b0, 8'h00, 8'h00, 8'h00, 1'b0},
		'{1'b0, 8'h04, 8'h00, 8'h81, 1'b0},
		'{1'b0, 8'h0C, 8'h00, 8'h00, 1'b0},
		'{1'b0, 8'h10, 8'h00, 8'h00, 1'b0},
		'{1'b0, 8'h14, 8'h00, 8'h00, 1'b1},
		'{1'b1, 8'h14, 8'hFF, 8'h00, 1'b1},
		'{1'b1, 8'h0C, 8'hA5, 8'h00, 1'b0},
		'{1'b0, 8'h0C, 8'h00, 8'hA4, 1'b0},
		'{1'b1, 8'h04, 8'hFF, 8'h00, 1'b0},
		'{1'b1, 8'h00, 8'h02, 8'h00, 1'b0},
		'{1'b0, 8'h04, 8'h00, 8'h9B, 1'b0},
		'{1'b0, 8'h00, 8'h00, 8'h02, 1'b0},
		'{1'b1, 8'h04, 8'h00, 8'h00, 1'b0},
		'{1'b0, 8'h04, 8'h00, 8'h81, 1'b0}
	};
	logic        clk    = 1'b0;
	logic        rst    = 1'b1;
	logic        psel   = 1'b0;
	logic        pen    = 1'b0;
	logic        pwr    = 1'b0;
	logic        tev    = 1'b0;
	logic        hs     = 1'b1;
	logic [7:0]  padr   = 8'h00;
	logic [31:0] pwd    = 32'h00000000;
	logic [31:0] prd;
	logic        pready;
	logic        perr;
	logic        sda_o;
	logic        sda_oe;
	logic        scl_o;
	logic        scl_oe;
	logic        irq;
	logic        wake;
	logic        m_sda;
	logic        m_scl;
	logic [7:0]  rd;
	logic [7:0]  q;
	logic        er;
	logic        ack;
	int          num_errors  = 0;
	int          checks_done = 0;
	int          irqs = 0;
	int          wakes = 0;
	int          cyc = 0;
	int          i0;
	// Open-drain wires with pull-ups: low while any party pulls
	wire logic   sda_w = ~(m_sda | (sda_oe & ~sda_o));
	wire logic   scl_w = ~(m_scl | (scl_oe & ~scl_o));

	always #20 clk = ~clk;

	isi_top dut_u (
		.CLK           (clk),
		.RESET         (rst),
		.PSEL          (psel),
		.PENABLE       (pen),
		.PWRITE        (pwr),
		.PADDR         (padr),
		.PWDATA        (pwd),
		.PRDATA        (prd),
		.PREADY        (pready),
		.PSLVERR       (perr),
		.SDA_IN        (sda_w),
		.SDA_OUT       (sda_o),
		.SDA_OE        (sda_oe),
		.SCL_IN        (scl_w),
		.SCL_OUT       (scl_o),
		.SCL_OE        (scl_oe),
		.HS_CLOCK_SEL  (hs),
		.TIMEOUT_EVENT (tev),
		.IRQ           (irq),
		.WAKE          (wake)
	);
	isi_bus_master mst_u (
		.sda     (sda_w),
		.scl     (scl_w),
		.sda_low (m_sda),
		.scl_low (m_scl)
	);

	task automatic tally_and_finish;
		if (num_errors == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Pulses are counted mid-cycle so the edge that launches them cannot race
	always @(negedge clk) begin
		cyc++;
		if (irq === 1'b1) irqs++;
		if (wake === 1'b1) wakes++;
		if (cyc == 30000) begin
			num_errors++;
			tally_and_finish();
		end
	end
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
			output logic [7:0] r, output logic e);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		padr <= a;
		pwd <= {24'h000000, d};
		@(posedge clk);
		pen <= 1'b1;
		// Request stands until the rising edge that finds PREADY high
		do @(posedge clk); while (pready !== 1'b1);
		r = prd[7:0];
		e = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		apb(1'b0, a, 8'h00, rd, er);
		`CHK($sformatf("reg %h", a), e, rd & m)
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d, rd, er);
	endtask
	// A release is registered on the edge that completes the access, after apb samples it, so skip any stale hold first
	task automatic wait_hold;
		while (scl_oe === 1'b1) @(negedge clk);
		while (scl_oe !== 1'b1) @(negedge clk);
	endtask

	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (5) @(posedge clk);
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, rows[i].d, rd, er);
			`CHK("slave error", rows[i].err, er)
			if (!rows[i].w) `CHK("read data", rows[i].e, rd)
		end
		i0 = irqs;
		fork
			begin
				mst_u.start();
				mst_u.xfer(8'hA4, 1'b1, q, ack);
				`CHK("address ack", 1'b0, ack)
				mst_u.xfer(8'hC3, 1'b1, q, ack);
				`CHK("data ack", 1'b0, ack)
				mst_u.stop();
			end
			begin
				wait_hold();
				repeat (30) @(negedge clk);
				`CHK("scl held", 1'b1, scl_oe)
				rd_chk(8'h04, 8'h64, 8'h60);
				wr(8'h04, 8'h00);
				apb(1'b0, 8'h08, 8'h00, rd, er);
				wait_hold();
				rd_chk(8'h04, 8'h80, 8'h80);
				rd_chk(8'h08, 8'hFF, 8'hC3);
				rd_chk(8'h04, 8'h80, 8'h00);
			end
		join
		rd_chk(8'h04, 8'hA0, 8'h80);
		`CHK("irq count", 2, irqs - i0)
		wr(8'h04, 8'h02);
		i0 = wakes;
		fork
			begin
				mst_u.start();
				mst_u.xfer(8'hA5, 1'b1, q, ack);
				`CHK("address ack", 1'b0, ack)
				mst_u.xfer(8'hFF, 1'b0, q, ack);
				`CHK("first byte", 8'h5A, q)
				mst_u.xfer(8'hFF, 1'b1, q, ack);
				`CHK("second byte", 8'h96, q)
				#400 `CHK("sda released", 1'b0, sda_oe)
				mst_u.stop();
			end
			begin
				wait_hold();
				rd_chk(8'h04, 8'h06, 8'h06);
				wr(8'h04, 8'h10);
				wr(8'h08, 8'h5A);
				wait_hold();
				rd_chk(8'h04, 8'h81, 8'h80);
				wr(8'h08, 8'h96);
			end
		join
		rd_chk(8'h04, 8'h01, 8'h01);
		`CHK("wake count", 1, wakes - i0)
		i0 = irqs;
		mst_u.start();
		mst_u.xfer(8'h22, 1'b1, q, ack);
		`CHK("foreign address ack", 1'b1, ack)
		mst_u.stop();
		rd_chk(8'h04, 8'h40, 8'h00);
		wr(8'h04, 8'h18);
		@(posedge clk) tev <= 1'b1;
		@(posedge clk) tev <= 1'b0;
		rd_chk(8'h04, 8'hFF, 8'h81);
		rd_chk(8'h10, 8'h40, 8'h40);
		wr(8'h10, 8'h00);
		rd_chk(8'h10, 8'h40, 8'h00);
		`CHK("irq count", 1, irqs - i0)
		wr(8'h00, 8'h00);
		mst_u.start();
		mst_u.xfer(8'hA4, 1'b1, q, ack);
		`CHK("disabled ack", 1'b1, ack)
		mst_u.stop();
		rd_chk(8'h04, 8'h20, 8'h00);
		// Debounce and its bypass, seen through the completion flag a short dip leaves
		wr(8'h00, 8'h06);
		apb(1'b0, 8'h08, 8'h00, rd, er);
		mst_u.glitch(40);
		rd_chk(8'h04, 8'hA0, 8'h00);
		mst_u.glitch(120);
		rd_chk(8'h04, 8'hA0, 8'h80);
		wr(8'h00, 8'h0A);
		wr(8'h04, 8'h02);
		apb(1'b0, 8'h08, 8'h00, rd, er);
		mst_u.glitch(120);
		rd_chk(8'h04, 8'hA0, 8'h00);
		hs <= 1'b0;
		mst_u.glitch(120);
		rd_chk(8'h04, 8'hA0, 8'h80);
		wr(8'h04, 8'h00);
		apb(1'b0, 8'h08, 8'h00, rd, er);
		mst_u.glitch(120);
		rd_chk(8'h04, 8'hA0, 8'h00);
		@(posedge clk) rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd_chk(8'h0C, 8'hFF, 8'h00);
		rd_chk(8'h04, 8'hFF, 8'h81);
		tally_and_finish();
	end
endmodule
`default_nettype wire
